// *** verilog/tmr_top.sv ***
// 24-bit timer with toggle, continuous, event count, capture and triggers
//
// Contract
// R01: Mode 10 counts periodic, toggles chosen pin
// R02: Toggle output starts high, square wave
// R03: Mode 11 flags match, keeps counting, wraps
// R04: New compare value used at once
// R05: Match flag with enable raises interrupt
// R06: Event counting advances once per event
// R07: Source select: event pin or frame start
// R08: Event pin debounce; source limits rate
// R09: Phase bit picks counted edge polarity
// R10: Event counting forces toggle onto extended pin
// R11: Capture copies count into capture register
// R12: Capture source: extended pin or comparator
// R13: Capture debounce and edge select; rate limit
// R14: Capture works in every counting mode
// R15: Capture edge sets flag, optional interrupt
// R16: Held capture flag blocks new captures
// R17: Capture function one resets the count
// R18: Trigger source: match or capture interrupt
// R19: Pulse to each enabled trigger target
// R20: Master line rises on count 0 to 1
// R21: At match line falls, master stops, partner stores
// R22: Even timer masters its odd partner
// R23: Match flag on equality; wake-up flag kept
// R24: Flags stay until software clears them
// R25: Partner counts own clock between line edges
`timescale 1ns/100ps
`default_nettype none
module tmr_top #(
	parameter bit PARTNER = 1'b0 // Odd timer of a pair
) (
	input wire logic hclk, // Bus clock, 25 MHz
	input wire logic hresetn, // Async reset, low
	input wire logic hsel, // Slave select
	input wire logic [31:0] haddr, // Byte address
	input wire logic [1:0] htrans, // Transfer type
	input wire logic hwrite, // Write strobe
	input wire logic [2:0] hsize, // Transfer size
	input wire logic [31:0] hwdata, // Write data
	input wire logic hready, // Bus ready
	output logic [31:0] hrdata, // Read data
	output logic hreadyout, // Slave ready
	output logic hresp, // Always OKAY
	input wire logic event_pin_in, // Main pin level
	output logic event_pin_out, // Main pin toggle
	output logic event_pin_oe, // Main pin drive
	input wire logic extended_pin_in, // Extended pin level
	output logic extended_pin_out, // Extended pin toggle
	output logic extended_pin_oe, // Extended pin drive
	input wire logic sof_in, // Frame start pulse
	input wire logic first_comparator, // Comparator 0 out
	input wire logic second_comparator, // Comparator 1 out
	input wire logic inter_timer_in, // Line from master
	output logic inter_timer_line, // Line to partner
	output logic match_irq, // Match interrupt
	output logic capture_irq, // Capture interrupt
	output tmr_pkg::tmr_trig_t trig // Trigger pulses
);
	localparam int unsigned W = tmr_pkg::CNT_W;
	// ------------------------------------------------------------
	// Bus slave
	// ------------------------------------------------------------
	logic wr_q;
	logic [tmr_pkg::AW-1:0] addr_q;
	logic [31:0] hrdata_q;
	logic [31:0] ctl_q, ext_q, trg_q, ctl_d;
	logic [W-1:0] cmp_q, cnt_q, cap_q, cnt_d, cap_d;
	logic mf_q, wk_q, cf_q, mf_d, wk_d, cf_d;
	logic tg_q, tg_d, itl_q, itl_d, itp_q;
	logic mi_q, ci_q;
	logic pm_out_q, pm_oe_q, px_out_q, px_oe_q;
	tmr_pkg::tmr_trig_t trig_q;
	tmr_pkg::tmr_part_t part_q, part_d;
	logic [31:0] rmux;

	wire sel = hsel & htrans[1] & hready;
	wire [tmr_pkg::AW-1:0] ra = haddr[tmr_pkg::AW-1:0];
	wire w_ctl = wr_q && addr_q == tmr_pkg::OFS_CTL;
	wire w_cmp = wr_q && addr_q == tmr_pkg::OFS_CMP;
	wire w_sts = wr_q && addr_q == tmr_pkg::OFS_STS;
	wire w_ext = wr_q && addr_q == tmr_pkg::OFS_EXT;
	wire w_trg = wr_q && addr_q == tmr_pkg::OFS_TRG;
	wire clr_mf = w_sts & hwdata[tmr_pkg::STS_MF];
	wire clr_wk = w_sts & hwdata[tmr_pkg::STS_WK];
	wire clr_cf = w_sts & hwdata[tmr_pkg::STS_CF];

	// Unmapped offsets read as zero
	always_comb begin
		case (ra)
			tmr_pkg::OFS_CTL: rmux = ctl_q;
			tmr_pkg::OFS_CMP: rmux = {8'h00, cmp_q};
			tmr_pkg::OFS_STS: rmux = {29'h0000_0000, cf_q, wk_q, mf_q};
			tmr_pkg::OFS_CNT: rmux = {8'h00, cnt_q};
			tmr_pkg::OFS_CAP: rmux = {8'h00, cap_q};
			tmr_pkg::OFS_EXT: rmux = ext_q;
			tmr_pkg::OFS_TRG: rmux = trg_q;
			default: rmux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			addr_q <= '0;
			hrdata_q <= 32'h0000_0000;
		end else begin
			wr_q <= sel & hwrite;
			addr_q <= ra;
			hrdata_q <= (sel & ~hwrite) ? rmux : 32'h0000_0000;
		end
	end

	// ------------------------------------------------------------
	// Field decode
	// ------------------------------------------------------------
	wire [1:0] mode_raw = ctl_q[tmr_pkg::CTL_MODE_HI:tmr_pkg::CTL_MODE_LO];
	wire tmr_pkg::tmr_mode_t mode = tmr_pkg::tmr_mode_t'(mode_raw);
	wire cnt_en = ctl_q[tmr_pkg::CTL_EN];
	wire ien = ctl_q[tmr_pkg::CTL_IEN];
	wire inter_en = ctl_q[tmr_pkg::CTL_ITEN];
	// R20 master is forced into event counting
	wire xcnt = ctl_q[tmr_pkg::CTL_XCNT] | inter_en;
	wire cfun = ext_q[tmr_pkg::EXT_CFUN];
	wire cien = ext_q[tmr_pkg::EXT_CIEN];
	wire [2:0] cedge = ext_q[tmr_pkg::EXT_EDGE_HI:tmr_pkg::EXT_EDGE_LO];

	// ------------------------------------------------------------
	// Input edge detection
	// ------------------------------------------------------------
	wire [3:0] in_vec = {second_comparator, first_comparator, extended_pin_in, event_pin_in};
	// R08 R13 debounce only on the two pins
	wire [3:0] db_vec = {2'b00, ext_q[tmr_pkg::EXT_CDB], ext_q[tmr_pkg::EXT_EDB]};
	logic [3:0] rise_v, fall_v;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_edge
			tmr_edge #(.DB_LEN(tmr_pkg::DB_LEN)) u_edge (
				.hclk(hclk),
				.hresetn(hresetn),
				.din(in_vec[gi]),
				.db_en(db_vec[gi]),
				.rise(rise_v[gi]),
				.fall(fall_v[gi])
			);
		end
	endgenerate

	// R09 phase one counts rising edges
	wire pin_evt = ext_q[tmr_pkg::EXT_PHASE] ? rise_v[0] : fall_v[0];
	// R07 pin or frame start
	wire src_evt = ext_q[tmr_pkg::EXT_ESRC] ? sof_in : pin_evt;
	// R13 edge select on the extended pin
	wire xpin_evt = (cedge == tmr_pkg::EDGE_FALL) ? fall_v[1] :
		(cedge == tmr_pkg::EDGE_RISE) ? rise_v[1] : (rise_v[1] | fall_v[1]);
	// R12 comparator output transitions
	wire acmp_evt = ext_q[tmr_pkg::EXT_ASEL] ? (rise_v[3] | fall_v[3]) :
		(rise_v[2] | fall_v[2]);
	// R12 R14 capture source, independent of counting mode
	wire cap_evt = ctl_q[tmr_pkg::CTL_CSRC] ? acmp_evt : xpin_evt;
	wire cap_rst = cap_evt & cfun;
	wire cap_set = cap_evt & ~cfun;

	// ------------------------------------------------------------
	// Partner side of the inter-timer pair
	// ------------------------------------------------------------
	wire itl_rise = PARTNER & inter_timer_in & ~itp_q;
	wire itl_fall = PARTNER & ~inter_timer_in & itp_q;
	wire part_run = part_q == tmr_pkg::TMR_PART_RUN;
	wire part_stop = part_run & itl_fall;

	// R22 pairing is by wiring the even line into the odd timer
	always_comb begin
		part_d = part_q;
		case (part_q)
			tmr_pkg::TMR_PART_IDLE: begin
				if (itl_rise) begin
					part_d = tmr_pkg::TMR_PART_RUN;
				end
			end
			tmr_pkg::TMR_PART_RUN: begin
				if (itl_fall) begin
					part_d = tmr_pkg::TMR_PART_IDLE;
				end
			end
			default: part_d = tmr_pkg::TMR_PART_IDLE;
		endcase
	end

	// ------------------------------------------------------------
	// Counter core
	// ------------------------------------------------------------
	// R06 R25 one step per event, per clock, or while partner runs
	wire tick = (cnt_en & (xcnt ? src_evt : 1'b1)) | part_run;
	// R04 R23 compare against the live register
	// R25 partner runs free, its own compare stays out of the way
	wire match = tick & ~part_run & (cnt_q == cmp_q);
	wire wrap_zero = match & (mode != tmr_pkg::TMR_CONT);
	wire stop_hw = match & ((mode == tmr_pkg::TMR_ONESHOT) | inter_en);

	always_comb begin
		cnt_d = cnt_q;
		// R17 capture event clears the count
		if (cap_rst | itl_rise) begin
			cnt_d = '0;
		// R01 R03 periodic style reload, or free run and wrap
		end else if (wrap_zero) begin
			cnt_d = '0;
		end else if (tick) begin
			cnt_d = cnt_q + 1'b1;
		end
	end

	// R21 master stops and drops its enable at match
	always_comb begin
		ctl_d = w_ctl ? (hwdata & tmr_pkg::CTL_WMASK) : ctl_q;
		if (stop_hw) begin
			ctl_d[tmr_pkg::CTL_EN] = 1'b0;
			ctl_d[tmr_pkg::CTL_ITEN] = 1'b0;
		end
	end

	// R20 line rises on 0 to 1, falls at match
	assign itl_d = (inter_en & match) ? 1'b0 :
		((inter_en & tick & cnt_q == '0) ? 1'b1 : itl_q);
	// R23 R24 hardware set wins over software clear
	assign mf_d = match | (mf_q & ~clr_mf);
	assign wk_d = (match & ien) | (wk_q & ~clr_wk);
	// R15 R24 capture flag
	assign cf_d = cap_set | part_stop | (cf_q & ~clr_cf);
	// R02 toggle on each match
	assign tg_d = (match & mode == tmr_pkg::TMR_TOGGLE) ? ~tg_q : tg_q;

	always_comb begin
		cap_d = cap_q;
		// R11 R16 R21 copy only while the flag is clear; partner stop always stores
		if (part_stop | (cap_set & ~cf_q)) begin
			cap_d = cnt_q;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctl_q <= tmr_pkg::REG_RST;
			ext_q <= tmr_pkg::REG_RST;
			trg_q <= tmr_pkg::REG_RST;
			cmp_q <= '0;
			cnt_q <= '0;
			cap_q <= '0;
			mf_q <= 1'b0;
			wk_q <= 1'b0;
			cf_q <= 1'b0;
			tg_q <= tmr_pkg::TGL_RST;
			itl_q <= 1'b0;
			itp_q <= 1'b0;
			part_q <= tmr_pkg::TMR_PART_IDLE;
		end else begin
			ctl_q <= ctl_d;
			ext_q <= w_ext ? (hwdata & tmr_pkg::EXT_WMASK) : ext_q;
			trg_q <= w_trg ? (hwdata & tmr_pkg::TRG_WMASK) : trg_q;
			cmp_q <= w_cmp ? hwdata[W-1:0] : cmp_q;
			cnt_q <= cnt_d;
			cap_q <= cap_d;
			mf_q <= mf_d;
			wk_q <= wk_d;
			cf_q <= cf_d;
			tg_q <= tg_d;
			itl_q <= itl_d;
			itp_q <= inter_timer_in;
			part_q <= part_d;
		end
	end

	// ------------------------------------------------------------
	// Registered outputs
	// ------------------------------------------------------------
	wire tgl_mode = mode == tmr_pkg::TMR_TOGGLE;
	// R01 R10 main pin is the event input while counting events
	wire use_ext = ctl_q[tmr_pkg::CTL_TSEL] | xcnt;
	// R18 trigger source choice
	wire trg_evt = trg_q[tmr_pkg::TRG_SRC] ? (cap_set & cien) : (match & ien);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mi_q <= 1'b0;
			ci_q <= 1'b0;
			trig_q <= '0;
			pm_out_q <= tmr_pkg::TGL_RST;
			pm_oe_q <= 1'b0;
			px_out_q <= tmr_pkg::TGL_RST;
			px_oe_q <= 1'b0;
		end else begin
			// R05 R15 interrupt levels follow the flags
			mi_q <= mf_d & ien;
			ci_q <= cf_d & cien;
			// R19 one pulse per enabled target
			trig_q.pwm <= trg_evt & trg_q[tmr_pkg::TRG_PWM];
			trig_q.adc <= trg_evt & trg_q[tmr_pkg::TRG_ADC];
			trig_q.dac <= trg_evt & trg_q[tmr_pkg::TRG_DAC];
			trig_q.dma <= trg_evt & trg_q[tmr_pkg::TRG_DMA];
			pm_out_q <= tg_d;
			pm_oe_q <= tgl_mode & ~use_ext;
			px_out_q <= tg_d;
			px_oe_q <= tgl_mode & use_ext;
		end
	end

	assign hrdata = hrdata_q;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign event_pin_out = pm_out_q;
	assign event_pin_oe = pm_oe_q;
	assign extended_pin_out = px_out_q;
	assign extended_pin_oe = px_oe_q;
	assign inter_timer_line = itl_q;
	assign match_irq = mi_q;
	assign capture_irq = ci_q;
	assign trig = trig_q;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_cont_keeps_count: assert property ( // R03
		match && mode == tmr_pkg::TMR_CONT && !cap_rst && !itl_rise |=> cnt_q == $past(cnt_q) + 1'b1)
		else $error("continuous mode cleared count at match");
	a_periodic_reload: assert property ( // R01
		match && mode == tmr_pkg::TMR_PERIODIC |=> cnt_q == '0)
		else $error("periodic count not reloaded");
	a_toggle_flips: assert property ( // R02
		match && tgl_mode |=> tg_q != $past(tg_q) && event_pin_out == tg_q && extended_pin_out == tg_q)
		else $error("toggle output did not flip");
	a_match_flag_irq: assert property ( // R05
		match && ien && !w_ctl |=> mf_q && wk_q ##0 match_irq)
		else $error("match flag or interrupt missing");
	a_cap_held: assert property ( // R16
		cf_q && !part_stop |=> $stable(cap_q))
		else $error("capture overwritten while flag set");
	a_cap_reset: assert property ( // R17
		cap_rst |=> cnt_q == '0)
		else $error("capture reset missed");
	a_event_step: assert property ( // R06
		cnt_en && xcnt && !src_evt && !part_run && !cap_rst && !itl_rise |=> $stable(cnt_q))
		else $error("count moved without event");
	a_master_stop: assert property ( // R21
		inter_en && match |=> !itl_q && !inter_en && !cnt_en)
		else $error("master did not stop at match");
	a_trig_pulse: assert property ( // R19
		match && ien && !trg_q[tmr_pkg::TRG_SRC] && trg_q[tmr_pkg::TRG_ADC] && !w_trg |=> trig.adc)
		else $error("trigger pulse missing");

	c_cont_match: cover property (match && mode == tmr_pkg::TMR_CONT);
	c_capture: cover property (cap_set && !cf_q);
	c_partner_stop: cover property (part_stop);
endmodule
`default_nettype wire

// *** verilog/tmr_pkg.sv ***
// Constants, types and register map of the capture/trigger timer
package tmr_pkg;
	localparam int unsigned CNT_W = 24;
	localparam int unsigned AW = 5;
	localparam int unsigned DB_LEN = 3;
	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [AW-1:0] OFS_CTL = 5'h00;
	localparam logic [AW-1:0] OFS_CMP = 5'h04;
	localparam logic [AW-1:0] OFS_STS = 5'h08;
	localparam logic [AW-1:0] OFS_CNT = 5'h0C;
	localparam logic [AW-1:0] OFS_CAP = 5'h10;
	localparam logic [AW-1:0] OFS_EXT = 5'h14;
	localparam logic [AW-1:0] OFS_TRG = 5'h18;
	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int unsigned CTL_EN = 30;
	localparam int unsigned CTL_IEN = 29;
	localparam int unsigned CTL_MODE_HI = 28;
	localparam int unsigned CTL_MODE_LO = 27;
	localparam int unsigned CTL_XCNT = 24;
	localparam int unsigned CTL_CSRC = 22;
	localparam int unsigned CTL_TSEL = 21;
	localparam int unsigned CTL_ITEN = 19;
	localparam int unsigned EXT_PHASE = 0;
	localparam int unsigned EXT_CFUN = 4;
	localparam int unsigned EXT_CIEN = 5;
	localparam int unsigned EXT_CDB = 6;
	localparam int unsigned EXT_EDB = 7;
	localparam int unsigned EXT_ASEL = 8;
	localparam int unsigned EXT_EDGE_HI = 14;
	localparam int unsigned EXT_EDGE_LO = 12;
	localparam int unsigned EXT_ESRC = 16;
	localparam int unsigned TRG_SRC = 0;
	localparam int unsigned TRG_PWM = 1;
	localparam int unsigned TRG_ADC = 2;
	localparam int unsigned TRG_DAC = 3;
	localparam int unsigned TRG_DMA = 4;
	localparam int unsigned STS_MF = 0;
	localparam int unsigned STS_WK = 1;
	localparam int unsigned STS_CF = 2;
	// ------------------------------------------------------------
	// Write masks and reset values
	// ------------------------------------------------------------
	localparam logic [31:0] CTL_WMASK = 32'h7968_0000;
	localparam logic [31:0] EXT_WMASK = 32'h0001_71F1;
	localparam logic [31:0] TRG_WMASK = 32'h0000_001F;
	localparam logic [31:0] REG_RST = 32'h0000_0000;
	localparam logic TGL_RST = 1'b1;
	localparam logic [2:0] EDGE_FALL = 3'h0;
	localparam logic [2:0] EDGE_RISE = 3'h1;

	typedef enum logic [1:0] {
		TMR_ONESHOT = 2'b00,
		TMR_PERIODIC = 2'b01,
		TMR_TOGGLE = 2'b10,
		TMR_CONT = 2'b11
	} tmr_mode_t;

	typedef enum logic [0:0] {
		TMR_PART_IDLE = 1'b0,
		TMR_PART_RUN = 1'b1
	} tmr_part_t;

	typedef struct packed {
		logic pwm;
		logic adc;
		logic dac;
		logic dma;
	} tmr_trig_t;
endpackage

// *** verilog/tmr_edge.sv ***
// Optional debounce and edge detection for one input line
`timescale 1ns/100ps
`default_nettype none
module tmr_edge #(
	parameter int unsigned DB_LEN = tmr_pkg::DB_LEN
) (
	input wire logic hclk, // Bus clock
	input wire logic hresetn, // Async reset, low
	input wire logic din, // Raw line level
	input wire logic db_en, // Debounce on
	output logic rise, // Rising edge pulse
	output logic fall // Falling edge pulse
);
	logic [DB_LEN-1:0] sh_q;
	logic lvl_q;
	logic lvl_d;
	wire all_hi = &sh_q;
	wire all_lo = ~|sh_q;

	// Debounce accepts a level only after DB_LEN equal samples
	assign lvl_d = db_en ? (all_hi ? 1'b1 : (all_lo ? 1'b0 : lvl_q)) : din;
	assign rise = lvl_d & ~lvl_q;
	assign fall = ~lvl_d & lvl_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sh_q <= '0;
			lvl_q <= 1'b0;
		end else begin
			sh_q <= {sh_q[DB_LEN-2:0], din};
			lvl_q <= lvl_d;
		end
	end
endmodule
`default_nettype wire

// *** tb/tmr_far.sv ***
// Far-side model: event pin, extended pin, frame start and comparators
`timescale 1ns/100ps
`default_nettype none
module tmr_far (
	input wire logic hclk, // Bus clock
	output logic event_line, // Event pin drive
	output logic ext_line, // Extended pin drive
	output logic sof, // Frame start pulse
	output logic cmp0, // First comparator
	output logic cmp1 // Second comparator
);
	logic [3:0] lv = 4'h0;
	initial sof = 1'b0;
	assign {cmp1, cmp0, ext_line, event_line} = lv;
	task automatic pulse(input int line, input int n);
		repeat (n) begin
			@(posedge hclk);
			lv[line] <= 1'b1;
			repeat (4) @(posedge hclk);
			lv[line] <= 1'b0;
			repeat (4) @(posedge hclk);
		end
	endtask
	task automatic frame(input int n);
		repeat (n) begin
			@(posedge hclk);
			sof <= 1'b1;
			@(posedge hclk);
			sof <= 1'b0;
			repeat (6) @(posedge hclk);
		end
	endtask
endmodule
`default_nettype wire

// *** tb/tmr_top_bench.sv ***
// Self-checking bench of the capture/trigger timer
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin n_mismatch++; \
	$display("BAD %s expected %h seen %h", nm, ex, got); end end
module tmr_top_bench;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [1:0] htrans = 2'h0;
	logic hreadyout, hresp, ev_out, ev_oe, ex_out, ex_oe, ev_far, ex_far, sof, c0, c1;
	logic line, m_irq, c_irq;
	logic hsel_b = 1'b0, to_b = 1'b0, pc_irq;
	logic [31:0] hrdata_b;
	logic [3:0] trig_seen = 4'h0;
	tmr_pkg::tmr_trig_t trig;
	wire logic ev_w = ev_oe ? ev_out : ev_far;
	wire logic ex_w = ex_oe ? ex_out : ex_far;
	int n_mismatch = 0, num_checks = 0, cycles = 0, k;
	initial begin
		forever #20 hclk = ~hclk;
	end
	tmr_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .event_pin_in(ev_w), .event_pin_out(ev_out),
		.event_pin_oe(ev_oe), .extended_pin_in(ex_w), .extended_pin_out(ex_out),
		.extended_pin_oe(ex_oe), .sof_in(sof), .first_comparator(c0), .second_comparator(c1),
		.inter_timer_in(1'b0), .inter_timer_line(line), .match_irq(m_irq),
		.capture_irq(c_irq), .trig(trig));
	// Odd partner fed by the even timer's line
	tmr_top #(.PARTNER(1'b1)) DUT_B (.hclk(hclk), .hresetn(hresetn), .hsel(hsel_b), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata_b), .hreadyout(), .hresp(), .event_pin_in(1'b0), .event_pin_out(),
		.event_pin_oe(), .extended_pin_in(1'b0), .extended_pin_out(), .extended_pin_oe(),
		.sof_in(1'b0), .first_comparator(1'b0), .second_comparator(1'b0),
		.inter_timer_in(line), .inter_timer_line(), .match_irq(), .capture_irq(pc_irq),
		.trig());
	tmr_far far (.hclk(hclk), .event_line(ev_far), .ext_line(ex_far), .sof(sof), .cmp0(c0),
		.cmp1(c1));
	always @(posedge hclk) begin
		trig_seen <= trig_seen | trig;
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			finish_test();
		end
	end
	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// One single AHB-Lite word transfer
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= ~to_b;
		hsel_b <= to_b;
		htrans <= 2'h2;
		haddr <= {27'h0, a};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		hsel_b <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		// Unselected slave returns zero
		rd = hrdata | hrdata_b;
	endtask
	task automatic rchk(input logic [4:0] a, input logic [31:0] ex, input string nm);
		bus(1'b0, a, 32'h0);
		`CHK(nm, ex, rd)
	endtask
	task automatic t_reset();
		rchk(tmr_pkg::OFS_CTL, 32'h0, "ctl");
		rchk(tmr_pkg::OFS_CNT, 32'h0, "cnt");
		rchk(5'h1C, 32'h0, "unmapped");
		`CHK("pins", 3'h6, {ev_out, ex_out, hresp})
	endtask
	task automatic t_toggle();
		logic p;
		bus(1'b1, tmr_pkg::OFS_CMP, 32'h3);
		bus(1'b1, tmr_pkg::OFS_CTL, 32'h5000_0000);
		repeat (2) begin
			p = ev_out;
			for (k = 0; k < 50 && ev_out === p; k++) @(posedge hclk);
		end
		`CHK("half period", 4, k)
		`CHK("main oe", 1'b1, ev_oe)
		bus(1'b1, tmr_pkg::OFS_CTL, 32'h5020_0000);
		repeat (3) @(posedge hclk);
		`CHK("ext oe", 1'b1, ex_oe)
		bus(1'b1, tmr_pkg::OFS_CTL, 32'h5100_0000);
		repeat (3) @(posedge hclk);
		`CHK("event mode oe", 2'h1, {ev_oe, ex_oe})
		bus(1'b1, tmr_pkg::OFS_CTL, 32'h0);
	endtask
	task automatic t_cont();
		bus(1'b1, tmr_pkg::OFS_STS, 32'h7);
		bus(1'b1, tmr_pkg::OFS_CMP, 32'h5);
		bus(1'b1, tmr_pkg::OFS_CTL, 32'h7800_0000);
		for (k = 0; k < 60 && m_irq !== 1'b1; k++) @(posedge hclk);
		`CHK("match irq", 1'b1, m_irq)
		rchk(tmr_pkg::OFS_STS, 32'h3, "sts");
		bus(1'b0, tmr_pkg::OFS_CNT, 32'h0);
		`CHK("no clear", 1'b1, rd > 32'h5)
		bus(1'b1, tmr_pkg::OFS_STS, 32'h1);
		rchk(tmr_pkg::OFS_STS, 32'h2, "sts clr");
		bus(1'b1, tmr_pkg::OFS_CMP, 32'h28);
		for (k = 0; k < 60 && m_irq !== 1'b1; k++) @(posedge hclk);
		`CHK("new cmp", 1'b1, m_irq)
		bus(1'b1, tmr_pkg::OFS_CTL, 32'h0);
		bus(1'b1, tmr_pkg::OFS_STS, 32'h1);
	endtask
	task automatic t_events();
		bus(1'b1, tmr_pkg::OFS_CMP, 32'h00FF_FFFF);
		bus(1'b1, tmr_pkg::OFS_CTL, 32'h5900_0000);
		bus(1'b1, tmr_pkg::OFS_EXT, 32'h0000_1011);
		far.pulse(1, 1);
		rchk(tmr_pkg::OFS_CNT, 32'h0, "cnt reset");
		bus(1'b1, tmr_pkg::OFS_EXT, 32'h0000_10A1);
		far.pulse(0, 5);
		rchk(tmr_pkg::OFS_CNT, 32'h5, "events");
		far.pulse(1, 1);
		rchk(tmr_pkg::OFS_CAP, 32'h5, "cap");
		`CHK("cap irq", 1'b1, c_irq)
		far.pulse(0, 2);
		far.pulse(1, 1);
		rchk(tmr_pkg::OFS_CAP, 32'h5, "cap held");
		rchk(tmr_pkg::OFS_CNT, 32'h7, "cnt kept");
		bus(1'b1, tmr_pkg::OFS_STS, 32'h4);
		@(posedge hclk);
		`CHK("cap irq clr", 1'b0, c_irq)
		bus(1'b1, tmr_pkg::OFS_CTL, 32'h5940_0000);
		far.pulse(2, 1);
		rchk(tmr_pkg::OFS_CAP, 32'h7, "cap cmp0");
		bus(1'b1, tmr_pkg::OFS_STS, 32'h4);
		bus(1'b1, tmr_pkg::OFS_EXT, 32'h0001_11A1);
		far.frame(3);
		rchk(tmr_pkg::OFS_CNT, 32'hA, "frames");
		`CHK("no trig", 4'h0, trig_seen)
		bus(1'b1, tmr_pkg::OFS_TRG, 32'h1F);
		far.pulse(3, 1);
		rchk(tmr_pkg::OFS_CAP, 32'hA, "cap cmp1");
		`CHK("trig all", 4'hF, trig_seen)
	endtask
	task automatic t_inter();
		// even timer drives the odd partner's line
		bus(1'b1, tmr_pkg::OFS_CTL, 32'h0);
		bus(1'b1, tmr_pkg::OFS_CMP, 32'h4);
		bus(1'b1, tmr_pkg::OFS_EXT, 32'h0000_1011);
		far.pulse(1, 1);
		to_b = 1'b1;
		bus(1'b1, tmr_pkg::OFS_EXT, 32'h0000_0020);
		to_b = 1'b0;
		bus(1'b1, tmr_pkg::OFS_CTL, 32'h4808_0000);
		far.pulse(0, 1);
		`CHK("line up", 1'b1, line)
		far.pulse(0, 4);
		`CHK("line down", 1'b0, line)
		rchk(tmr_pkg::OFS_CTL, 32'h0800_0000, "ctl self clear");
		to_b = 1'b1;
		bus(1'b0, tmr_pkg::OFS_CAP, 32'h0);
		// Five events nine cycles apart; pin and line sampling shift by a cycle
		`CHK("span", 1'b1, rd >= 32'h22 && rd <= 32'h24)
		rchk(tmr_pkg::OFS_STS, 32'h4, "partner sts");
		`CHK("partner irq", 1'b1, pc_irq)
		to_b = 1'b0;
	endtask
	initial begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		t_toggle();
		t_cont();
		t_events();
		t_inter();
		finish_test();
	end
endmodule
`default_nettype wire
